//--- rtl/ctg_top.v
// What this block does
// - two independent 32-bit counters, selected by element index 0 or 1
// - each counter has its own clock input, gate input, pulse output
// - index 0 addresses counter 0, index 1 addresses counter 1
// - listed counter gives two entries: low half first, then high half
// - listed counters are sampled at the analog input sample clock
// - internal source: pulse output runs at the programmed frequency
// - external source: counting happens on clock input rising edges
// - internal clock is 36 MHz base divided by divider 2 upward
// - gate none: enabled as soon as software enables, gate ignored
// - low-level gate: counts while gate low, stops while high
// - high-level gate: counts while gate high, stops while low
// - falling-edge gate: enabled after a high-to-low gate transition
// - rising-edge gate: enabled after a low-to-high gate transition
//
// The address map and the APB register port are this design's own decisions.
`include "ctg_consts.vh"

module ctg_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [1:0]  ctr_clk_in,
    input  wire [1:0]  ctr_gate_in,
    output wire [1:0]  ctr_pulse_out,
    input  wire        ai_sample,
    output reg  [15:0] acq_data,
    output reg         acq_valid,
    output reg         acq_ctr,
    output reg         acq_upper
);

    // ***********************************************************
    // storage
    // ***********************************************************
    reg  [4:0]  ctrl     [0:1];
    reg  [32:0] divider  [0:1];
    reg  [31:0] snap     [0:1];
    reg  [1:0]  list_en;
    reg  [6:0]  base_acc;
    reg         base_tick;
    reg  [1:0]  entry;
    reg         emitting;
    wire [31:0] count    [0:1];
    wire [1:0]  active;
    wire        setup_ok;
    wire        wr_fire;
    wire        rd_hit;
    wire        wr_ch;
    wire [3:0]  wr_off;
    wire [7:0]  next_acc;
    wire [2:0]  next_idx;
    integer     i;

    // ***********************************************************
    // helper functions
    // ***********************************************************
    // true when the address hits a channel register block
    function is_chan;
        input [7:0] a;
        begin
            is_chan = (a < `CTG_ADDR_LIST) && (a[1:0] == 2'h0);
        end
    endfunction

    // true when the address hits any mapped word
    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = is_chan(a) ||
                        a == `CTG_ADDR_LIST ||
                        a == `CTG_ADDR_STATUS;
        end
    endfunction

    // read-back word for a mapped address
    function [31:0] read_word;
        input [7:0] a;
        reg         ch;
        begin
            ch = a[4];
            read_word = 32'h0;
            if (is_chan(a)) begin
                case (a[3:0])
                    `CTG_OFF_CTRL:  read_word = {27'h0, ctrl[ch]};
                    `CTG_OFF_DIVLO: read_word = divider[ch][31:0];
                    `CTG_OFF_DIVHI: read_word = {31'h0, divider[ch][32]};
                    `CTG_OFF_COUNT: read_word = count[ch];
                    default:        read_word = 32'h0;
                endcase
            end else if (a == `CTG_ADDR_LIST) begin
                read_word = {30'h0, list_en};
            end else if (a == `CTG_ADDR_STATUS) begin
                read_word = {28'h0, emitting, 1'b0, active};
            end
        end
    endfunction

    // ***********************************************************
    // apb slave: one wait state, answer registered
    // ***********************************************************
    assign setup_ok = psel && penable && !pready;
    assign wr_fire  = psel && penable && pready && pwrite;
    assign rd_hit   = is_mapped(paddr);
    assign wr_ch    = paddr[4];
    assign wr_off   = paddr[3:0];

    // ready, error and read data latched in first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setup_ok;
            pslverr <= setup_ok && !rd_hit;
            if (setup_ok && !pwrite && rd_hit)
                prdata <= read_word(paddr);
            else if (setup_ok)
                prdata <= 32'h0;
        end
    end

    // ***********************************************************
    // software registers
    // ***********************************************************
    // writes take effect on the completing access edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < 2; i = i + 1) begin
                ctrl[i]    <= `CTG_CTRL_RST;
                divider[i] <= `CTG_DIV_RST;
            end
            list_en <= `CTG_LIST_RST;
        end else if (wr_fire) begin
            if (is_chan(paddr)) begin
                case (wr_off)
                    `CTG_OFF_CTRL:
                        ctrl[wr_ch] <= pwdata[4:0];
                    `CTG_OFF_DIVLO:
                        divider[wr_ch][31:0] <= pwdata;
                    `CTG_OFF_DIVHI:
                        divider[wr_ch][32] <= pwdata[0];
                    default:
                        divider[wr_ch] <= divider[wr_ch];
                endcase
            end else if (paddr == `CTG_ADDR_LIST) begin
                list_en <= pwdata[1:0];
            end
        end
    end

    // ***********************************************************
    // 36 MHz base tick from the 100 MHz clock
    // ***********************************************************
    // sum one bit wider so it cannot wrap past 127
    assign next_acc = {1'b0, base_acc} + {1'b0, `CTG_BASE_STEP};

    // fractional accumulator gives 36 ticks per 100 cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_acc  <= 7'h0;
            base_tick <= 1'b0;
        end else if (next_acc >= {1'b0, `CTG_BASE_MOD}) begin
            base_acc  <= next_acc[6:0] - `CTG_BASE_MOD;
            base_tick <= 1'b1;
        end else begin
            base_acc  <= next_acc[6:0];
            base_tick <= 1'b0;
        end
    end

    // ***********************************************************
    // counter channels
    // ***********************************************************
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : chan
            // each channel has its own clock, gate and pulse pins
            ctg_chan u_chan (
                .pclk       (pclk),
                .presetn    (presetn),
                .base_tick  (base_tick),
                .sw_enable  (ctrl[g][`CTG_CTRL_EN]),
                .clk_src    (ctrl[g][`CTG_CTRL_SRC]),
                .gate_type  (ctrl[g][`CTG_CTRL_GATE_HI:`CTG_CTRL_GATE_LO]),
                .divider    (divider[g]),
                .ext_clk_in (ctr_clk_in[g]),
                .gate_in    (ctr_gate_in[g]),
                .count      (count[g]),
                .pulse_out  (ctr_pulse_out[g]),
                .active     (active[g])
            );
        end
    endgenerate

    // ***********************************************************
    // acquisition list readout
    // ***********************************************************
    // next entry index, skipping counters not in the list
    function [2:0] next_entry;
        input [1:0] cur;
        input [1:0] en;
        begin
            if (cur[0] == 1'b0)
                next_entry = {1'b0, cur[1], 1'b1};
            else if (cur[1] == 1'b0 && en[1])
                next_entry = 3'h2;
            else
                next_entry = 3'h4;  // past the end
        end
    endfunction

    // entry that follows the current one
    assign next_idx = next_entry(entry, list_en);

    // snapshot on sample clock, then emit low then high words
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            snap[0]   <= 32'h0;
            snap[1]   <= 32'h0;
            entry     <= 2'h0;
            emitting  <= 1'b0;
            acq_data  <= 16'h0;
            acq_valid <= 1'b0;
            acq_ctr   <= 1'b0;
            acq_upper <= 1'b0;
        end else begin
            acq_valid <= 1'b0;
            if (!emitting) begin
                if (ai_sample && list_en != 2'h0) begin
                    snap[0]  <= count[0];
                    snap[1]  <= count[1];
                    entry    <= list_en[0] ? 2'h0 : 2'h2;
                    emitting <= 1'b1;
                end
            end else begin
                acq_valid <= 1'b1;
                acq_ctr   <= entry[1];
                acq_upper <= entry[0];
                acq_data  <= entry[0] ? snap[entry[1]][31:16]
                                      : snap[entry[1]][15:0];
                if (next_idx == 3'h4)
                    emitting <= 1'b0;
                else
                    entry <= next_idx[1:0];
            end
        end
    end

endmodule

//--- common/ctg_consts.vh
`ifndef CTG_CONSTS_VH
`define CTG_CONSTS_VH

// ***********************************************************
// rates and timing
// ***********************************************************
`define CTG_PCLK_HZ       100000000
`define CTG_BASE_HZ       36000000
// base tick accumulator: add 36 per pclk cycle, wrap at 100
`define CTG_BASE_STEP     7'h24
`define CTG_BASE_MOD      7'h64
`define CTG_DIV_MIN       33'h000000002
`define CTG_DIV_MAX       33'h1258D0980

// ***********************************************************
// register byte offsets
// ***********************************************************
`define CTG_OFF_CTRL      4'h0
`define CTG_OFF_DIVLO     4'h4
`define CTG_OFF_DIVHI     4'h8
`define CTG_OFF_COUNT     4'hC
`define CTG_CH_STRIDE     8'h10
`define CTG_ADDR_LIST     8'h20
`define CTG_ADDR_STATUS   8'h24
`define CTG_ADDR_TOP      8'h27

// ***********************************************************
// control field layout and reset values
// ***********************************************************
`define CTG_CTRL_EN       0
`define CTG_CTRL_SRC      1
`define CTG_CTRL_GATE_LO  2
`define CTG_CTRL_GATE_HI  4
`define CTG_CTRL_RST      5'h00
`define CTG_DIV_RST       33'h000000002
`define CTG_LIST_RST      2'h0

// ***********************************************************
// gate types
// ***********************************************************
`define CTG_GATE_NONE     3'h0
`define CTG_GATE_LOW      3'h1
`define CTG_GATE_HIGH     3'h2
`define CTG_GATE_FALL     3'h3
`define CTG_GATE_RISE     3'h4

`endif

//--- rtl/ctg_chan.v
`include "ctg_consts.vh"

// one counter channel: sync, gating, divider, count, pulse out
module ctg_chan (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        base_tick,
    input  wire        sw_enable,
    input  wire        clk_src,
    input  wire [2:0]  gate_type,
    input  wire [32:0] divider,
    input  wire        ext_clk_in,
    input  wire        gate_in,
    output reg  [31:0] count,
    output reg         pulse_out,
    output reg         active
);

    // ***********************************************************
    // input synchronisers
    // ***********************************************************
    reg  [1:0]  clk_sync;
    reg  [1:0]  gate_sync;
    reg         clk_prev;
    reg         gate_prev;
    reg         edge_armed;
    reg  [32:0] div_cnt;
    wire        clk_rise;
    wire        gate_rise;
    wire        gate_fall;
    wire        gate_ok;
    wire        int_tick;
    wire        count_tick;
    wire [32:0] div_eff;

    // two flops per input, first read only by second
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sync  <= 2'h0;
            gate_sync <= 2'h0;
            clk_prev  <= 1'b0;
            gate_prev <= 1'b0;
        end else begin
            clk_sync  <= {clk_sync[0], ext_clk_in};
            gate_sync <= {gate_sync[0], gate_in};
            clk_prev  <= clk_sync[1];
            gate_prev <= gate_sync[1];
        end
    end

    assign clk_rise  = clk_sync[1] & ~clk_prev;
    assign gate_rise = gate_sync[1] & ~gate_prev;
    assign gate_fall = ~gate_sync[1] & gate_prev;

    // ***********************************************************
    // gate decision
    // ***********************************************************
    // edge gates latch enabled once the edge is seen
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_armed <= 1'b0;
        end else if (!sw_enable) begin
            edge_armed <= 1'b0;
        end else if (gate_type == `CTG_GATE_FALL && gate_fall) begin
            edge_armed <= 1'b1;
        end else if (gate_type == `CTG_GATE_RISE && gate_rise) begin
            edge_armed <= 1'b1;
        end
    end

    assign gate_ok =
        (gate_type == `CTG_GATE_NONE) ? 1'b1 :
        (gate_type == `CTG_GATE_LOW)  ? ~gate_sync[1] :
        (gate_type == `CTG_GATE_HIGH) ? gate_sync[1] :
        edge_armed;

    // ***********************************************************
    // internal clock divider
    // ***********************************************************
    assign div_eff  = (divider < `CTG_DIV_MIN) ? `CTG_DIV_MIN :
                      (divider > `CTG_DIV_MAX) ? `CTG_DIV_MAX :
                      divider;
    assign int_tick = base_tick && (div_cnt >= div_eff - 33'h1);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 33'h0;
        end else if (!(sw_enable && gate_ok) || clk_src) begin
            div_cnt <= 33'h0;
        end else if (base_tick) begin
            div_cnt <= int_tick ? 33'h0 : div_cnt + 33'h1;
        end
    end

    // external mode counts rising edges of the clock input
    assign count_tick = clk_src ? clk_rise : int_tick;

    // ***********************************************************
    // count, pulse output and activity
    // ***********************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count     <= 32'h0;
            pulse_out <= 1'b0;
            active    <= 1'b0;
        end else begin
            active <= sw_enable && gate_ok;
            if (!sw_enable) begin
                count     <= 32'h0;
                pulse_out <= 1'b0;
            end else if (gate_ok) begin
                if (count_tick)
                    count <= count + 32'h1;
                if (clk_src)
                    pulse_out <= clk_sync[1];
                else if (base_tick)
                    // high for first half of each divided period
                    pulse_out <= (div_cnt < (div_eff >> 1)) &&
                                 !int_tick;
            end else begin
                pulse_out <= 1'b0;
            end
        end
    end

endmodule

//--- test/ctg_src_model.sv
// external clock and gate sources for both counters
module ctg_src_model (
    input  wire logic [1:0] run,
    input  wire logic [1:0] gate_lvl,
    output logic      [1:0] ext_clk,
    output logic      [1:0] gate
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF_NS = 37;
    initial ext_clk = 2'h0;
    // toggle near 13.5 MHz while running, park low when stopped
    always begin
        #HALF_NS;
        for (int i = 0; i < 2; i++)
            ext_clk[i] = run[i] ? ~ext_clk[i] : 1'b0;
    end
    // gate lines follow the commanded levels
    assign gate = gate_lvl;
endmodule

//--- test/ctg_top_chk.sv
module ctg_top_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ai_sample,
    input wire logic        acq_valid,
    input wire logic        acq_ctr,
    input wire logic        acq_upper
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ***********************************************************
    // register bus answers and list readout order
    // ***********************************************************
    chk_ready_wait: assert property (
        psel && penable && !pready |=> pready)
        else $error("access not answered after one wait");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held over one cycle");
    chk_err_ready: assert property (
        pslverr |-> pready && psel && penable)
        else $error("error outside an access");
    chk_err_rdata: assert property (
        pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    chk_acq_pair: assert property (acq_valid && !acq_upper |=>
        acq_valid && acq_upper && $stable(acq_ctr))
        else $error("low half not followed by high half");
    chk_acq_low_first: assert property (acq_valid && acq_upper |->
        $past(acq_valid) && !$past(acq_upper))
        else $error("high half without low half");
    chk_acq_cause: assert property ($rose(acq_valid) |->
        $past(ai_sample, 2) || $past(ai_sample))
        else $error("entries without sample clock");
    chk_acq_order: assert property (
        acq_valid && acq_upper && !acq_ctr |=>
        !acq_valid || (acq_ctr && !acq_upper))
        else $error("counter 1 not after counter 0");
endmodule

bind ctg_top ctg_top_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ai_sample(ai_sample),
    .acq_valid(acq_valid), .acq_ctr(acq_ctr), .acq_upper(acq_upper));

//--- test/tb_top.sv
`include "ctg_consts.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    miscompares++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, b;
    logic [31:0] pwdata = 32'h0, prdata, r, seed;
    logic        pready, pslverr, ai_sample = 1'b0;
    logic [1:0]  ctr_clk_in, ctr_gate_in, ctr_pulse_out;
    logic [1:0]  run = 2'h0, gate_lvl = 2'h0;
    logic [15:0] acq_data;
    logic        acq_valid, acq_ctr, acq_upper;
    logic [64:0] apb_q[$], m_e;
    logic [17:0] acq_q[$], a_e;
    int          miscompares = 0, n_compared = 0, ch, e;
    int          pc[2] = '{0, 0};
    int          dv[2] = '{2, 9};

    always #5 pclk = ~pclk;

    ctg_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ctr_clk_in(ctr_clk_in), .ctr_gate_in(ctr_gate_in),
        .ctr_pulse_out(ctr_pulse_out), .ai_sample(ai_sample),
        .acq_data(acq_data), .acq_valid(acq_valid), .acq_ctr(acq_ctr),
        .acq_upper(acq_upper));

    ctg_src_model u_src (.run(run), .gate_lvl(gate_lvl),
        .ext_clk(ctr_clk_in), .gate(ctr_gate_in));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic results();
        if (miscompares == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // expectation is {data mask, error, data}
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic [64:0] x, output logic [31:0] q);
        apb_q.push_back(x);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, 65'h0, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, {32'hFFFFFFFF, 1'b0, x}, q);
    endtask

    // n rising edges on one external clock, then let them settle
    task automatic run_edges(input int c, input int n);
        run[c] = 1'b1;
        repeat (n) @(posedge ctr_clk_in[c]);
        run[c] = 1'b0;
        repeat (5) @(posedge pclk);
    endtask

    // bus and list monitors take the oldest expectation
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1) begin
            m_e = apb_q.pop_front();
            `CHK("apb", m_e[32:0], {pslverr, prdata & m_e[64:33]})
        end
    always @(posedge pclk)
        if (acq_valid === 1'b1) begin
            a_e = acq_q.pop_front();
            `CHK("acq", a_e, {acq_ctr, acq_upper, acq_data})
        end
    always @(posedge ctr_pulse_out[0])
        pc[0]++;
    always @(posedge ctr_pulse_out[1])
        pc[1]++;

    initial begin
        #200000;
        miscompares++;
        results();
    end

    // ***********************************************************
    // main sequence
    // ***********************************************************
    initial begin
        seed = 32'hD2DD6CF0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, read-only count, unmapped places
        for (int c = 0; c < 2; c++) begin
            b = 8'(c * 16);
            rd(b + `CTG_OFF_CTRL, 32'h0);
            rd(b + `CTG_OFF_DIVLO, 32'(`CTG_DIV_RST));
            rd(b + `CTG_OFF_DIVHI, 32'h0);
            seed = lfsr(seed);
            wr(b + `CTG_OFF_COUNT, seed);
            rd(b + `CTG_OFF_COUNT, 32'h0);
        end
        rd(`CTG_ADDR_LIST, 32'h0);
        apb(1'b0, 8'h28, 32'h0, {32'hFFFFFFFF, 1'b1, 32'h0}, r);
        apb(1'b1, 8'h2C, seed, {32'h0, 1'b1, 32'h0}, r);
        seed = lfsr(seed);
        wr(`CTG_OFF_DIVLO, seed | 32'h2);
        rd(`CTG_OFF_DIVLO, seed | 32'h2);
        wr(8'h18, 32'h1);
        rd(8'h18, 32'h1);
        wr(8'h18, 32'h0);
        // internal source on counter 1 at two dividers
        foreach (dv[i]) begin
            wr(8'h10, 32'h0);
            wr(8'h14, 32'(dv[i]));
            wr(8'h10, 32'h1);
            pc[1] = 0;
            repeat (1000) @(posedge pclk);
            e = 360 / dv[i];
            `CHK("pulses", 1'b1, pc[1] >= e - 2 && pc[1] <= e + 2)
            apb(1'b0, 8'h1C, 32'h0, 65'h0, r);
            `CHK("count", 1'b1, r >= e - 2 && r <= e + 3)
        end
        rd(`CTG_ADDR_STATUS, 32'h2);
        wr(8'h10, 32'h0);
        // every gate type with the external clock
        for (int g = 0; g < 5; g++) begin
            ch = g % 2;
            b = 8'(ch * 16);
            e = (g == 0) ? 8 : 5 + g;
            gate_lvl[ch] <= (g == 2 || g == 4) ? 1'b0 : 1'b1;
            repeat (5) @(posedge pclk);
            wr(b, 32'h0);
            pc[ch] = 0;
            wr(b, 32'(g * 4 + 3));
            run_edges(ch, 3);
            gate_lvl[ch] <= ~gate_lvl[ch];
            repeat (5) @(posedge pclk);
            run_edges(ch, 5 + g);
            rd(b + `CTG_OFF_COUNT, 32'(e));
            `CHK("pulse", e, pc[ch])
        end
        // list readout: counter 0 holds 9, counter 1 holds 8
        wr(`CTG_ADDR_LIST, 32'h3);
        acq_q = {acq_q, 18'h00009, 18'h10000, 18'h20008, 18'h30000};
        ai_sample <= 1'b1;
        @(posedge pclk);
        ai_sample <= 1'b0;
        repeat (8) @(posedge pclk);
        wr(`CTG_ADDR_LIST, 32'h2);
        acq_q = {acq_q, 18'h20008, 18'h30000};
        ai_sample <= 1'b1;
        repeat (2) @(posedge pclk);
        ai_sample <= 1'b0;
        repeat (8) @(posedge pclk);
        `CHK("acq left", 0, acq_q.size())
        `CHK("apb left", 0, apb_q.size())
        results();
    end
endmodule
